/* verif/ofrl_fault_limits_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrl_fault_limits_checker #(parameter int PAGES = 2) (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic cmd_valid, // strobe
    input wire logic cmd_write, // write
    input wire logic write_protect, // protect
    input wire logic clear_faults, // clear
    input wire logic cmd_ack, // ack
    input wire logic cmd_nack, // nack
    input wire logic bias_ok, // bias
    input wire ofrl_pkg::ofrl_sample_t sample, // sample
    input wire logic blank_done, // blanking over
    input wire logic [PAGES-1:0] avg_oc_event, // avg oc
    input wire logic [PAGES-1:0] avg_uc_event, // avg uc
    input wire logic [PAGES-1:0] output_enable, // enable
    input wire logic alert_line_n, // alert
    input wire logic [PAGES-1:0] uv_status, // uv bit
    input wire logic [PAGES-1:0] oc_status, // oc bit
    input wire logic [PAGES-1:0] uc_status, // uc bit
    input wire logic [PAGES-1:0] oc_response_req, // oc req
    input wire logic [PAGES-1:0] uc_response_req // uc req
);
    logic [3*PAGES-1:0] st;
    assign st = {uv_status, oc_status, uc_status};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    chk_alert_status: assert property (alert_line_n == ~|st)
        else $error("alert differs from status");
    chk_status_sticky: assert property (!clear_faults |=> (st & $past(st)) == $past(st))
        else $error("status bit dropped");
    chk_oc_req_sets: assert property (|oc_response_req |=>
        (oc_status & $past(oc_response_req)) == $past(oc_response_req))
        else $error("oc status not set");
    chk_peak_blanked: assert property (!(sample.valid && blank_done) ##1 !(|avg_oc_event)
        |-> !(|oc_response_req))
        else $error("oc request without sample");
    chk_valley_blanked: assert property (!(sample.valid && blank_done) ##1 !(|avg_uc_event)
        |-> !(|uc_response_req))
        else $error("uc request without sample");
    chk_answer_once: assert property (cmd_valid |=> cmd_ack != cmd_nack)
        else $error("no single answer");
    chk_no_stray: assert property (!cmd_valid |=> !cmd_ack && !cmd_nack)
        else $error("stray answer");
    chk_wp_nack: assert property (cmd_valid && cmd_write && write_protect |=> cmd_nack)
        else $error("protected write taken");
    chk_bias_gate: assert property (!bias_ok [*3] |-> output_enable == '0)
        else $error("output on without bias");
    chk_uv_masked: assert property (!output_enable[0] [*3] |=> !$rose(uv_status[0]))
        else $error("uv while off");
    cover property ($rose(|oc_status));
    cover property ($rose(|uc_status));
    cover property ($rose(output_enable[0]));
endmodule : ofrl_fault_limits_checker
bind ofrl_fault_limits ofrl_fault_limits_checker #(.PAGES(PAGES)) ofrl_fault_limits_checker_i (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .write_protect(write_protect), .clear_faults(clear_faults), .cmd_ack(cmd_ack),
    .cmd_nack(cmd_nack), .bias_ok(bias_ok), .sample(sample), .blank_done(blank_done),
    .avg_oc_event(avg_oc_event), .avg_uc_event(avg_uc_event), .output_enable(output_enable),
    .alert_line_n(alert_line_n), .uv_status(uv_status), .oc_status(oc_status),
    .uc_status(uc_status), .oc_response_req(oc_response_req),
    .uc_response_req(uc_response_req));
`default_nettype wire

/* verif/ofrl_fault_limits_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrl_fault_limits_test;
    localparam int TCK = 4;
    localparam int RT = 2 * ofrl_pkg::RETRY_UNIT_MS * TCK;
    localparam logic [63:0] STRAPS = 64'h0028_001E_0014_000A;
    localparam logic [15:0] OC_RST = STRAPS[31:16];
    localparam logic [10:0] OC_M = STRAPS[26:16];
    localparam logic [15:0] UC_RST = {STRAPS[31:27], -OC_M};
    localparam logic [15:0] OVER = 16'h01F0;
    localparam logic [15:0] UNDER = 16'hFE10;
    logic mclk = 1'b0, rst = 1'b1, write_protect = 1'b0, clear_faults = 1'b0;
    logic bias_ok = 1'b0, blank_done = 1'b1;
    logic [1:0] cfg_strap = 2'b01, uv_detect = 2'b00, power_good_flag = 2'b00;
    logic [1:0] enable_pin = 2'b00, operation_on = 2'b00, other_fault = 2'b00;
    logic [1:0] avg_oc_event = 2'b00, avg_uc_event = 2'b00;
    logic [3:0] consec_needed = 4'h3;
    ofrl_pkg::ofrl_sample_t sample = '0;
    wire logic cmd_valid, cmd_write, cmd_ack, cmd_nack, alert_line_n;
    wire logic [0:0] cmd_page;
    wire logic [7:0] cmd_code;
    wire logic [15:0] cmd_wdata, cmd_rdata;
    wire logic [1:0] output_enable, uv_status, oc_status, uc_status, oc_req, uc_req;
    int n_errors = 0, checks_done = 0;
    always #25 mclk = ~mclk;
    ofrl_host_model ofrl_host_model_i (.mclk(mclk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_page(cmd_page), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata));
    ofrl_fault_limits #(.PAGES(2), .TICK_CYCLES(TCK), .STRAP_OC_LIMITS(STRAPS))
    ofrl_fault_limits_i (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .write_protect(write_protect), .clear_faults(clear_faults), .cmd_ack(cmd_ack),
        .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata), .cfg_strap(cfg_strap),
        .uv_detect(uv_detect), .power_good_flag(power_good_flag), .enable_pin(enable_pin),
        .operation_on(operation_on), .bias_ok(bias_ok), .other_fault(other_fault),
        .sample(sample), .blank_done(blank_done), .consec_needed(consec_needed),
        .avg_oc_event(avg_oc_event), .avg_uc_event(avg_uc_event),
        .output_enable(output_enable), .alert_line_n(alert_line_n), .uv_status(uv_status),
        .oc_status(oc_status), .uc_status(uc_status), .oc_response_req(oc_req),
        .uc_response_req(uc_req));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d,
            input logic [1:0] ea);
        logic [1:0] an;
        logic [15:0] r;
        ofrl_host_model_i.xfer(1'b1, p, c, d, an, r);
        chk({14'h0000, an}, {14'h0000, ea});
    endtask : wr
    task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] e);
        logic [1:0] an;
        logic [15:0] r;
        ofrl_host_model_i.xfer(1'b0, p, c, 16'h0000, an, r);
        chk({14'h0000, an}, 16'h0002);
        chk(r, e);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic smp(input logic p, input logic [15:0] a, input int n);
        repeat (n) begin
            @(negedge mclk);
            sample = {1'b1, p, a};
        end
        @(negedge mclk);
        sample.valid = 1'b0;
    endtask : smp
    task automatic st(input logic [1:0] oe, uv, oc, uc, input logic al);
        cyc(2);
        chk({7'h00, output_enable, uv_status, oc_status, uc_status, alert_line_n},
            {7'h00, oe, uv, oc, uc, al});
    endtask : st
    task automatic clr;
        @(negedge mclk);
        clear_faults = 1'b1;
        @(negedge mclk);
        clear_faults = 1'b0;
    endtask : clr
    task automatic uv_hit(input int n);
        uv_detect = 2'b01;
        cyc(n);
        uv_detect = 2'b00;
    endtask : uv_hit
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(8);
        rst = 1'b0;
        cyc(5);
        bias_ok = 1'b1;
        for (int p = 0; p < 2; p++) begin
            rd(p[0], ofrl_pkg::CMD_UV_ACTION, {8'h00, ofrl_pkg::UV_ACTION_RST});
            rd(p[0], ofrl_pkg::CMD_OC_LIMIT, OC_RST);
            rd(p[0], ofrl_pkg::CMD_UC_LIMIT, UC_RST);
        end
        wr(1'b1, ofrl_pkg::CMD_OC_LIMIT, 16'hF828, 2'b10);
        rd(1'b1, ofrl_pkg::CMD_OC_LIMIT, 16'hF828);
        rd(1'b0, ofrl_pkg::CMD_OC_LIMIT, OC_RST);
        write_protect = 1'b1;
        wr(1'b1, ofrl_pkg::CMD_UC_LIMIT, 16'h0001, 2'b01);
        rd(1'b1, ofrl_pkg::CMD_UC_LIMIT, UC_RST);
        write_protect = 1'b0;
        wr(1'b0, 8'h47, 16'h0000, 2'b01);
        smp(1'b0, OVER, 2);
        smp(1'b0, OC_RST << 4, 1);
        smp(1'b0, OVER, 2);
        blank_done = 1'b0;
        smp(1'b0, OVER, 3);
        st(2'b00, 2'b00, 2'b00, 2'b00, 1'b1);
        blank_done = 1'b1;
        smp(1'b0, OVER, 1);
        st(2'b00, 2'b00, 2'b01, 2'b00, 1'b0);
        smp(1'b1, 16'h0190, 3);
        st(2'b00, 2'b00, 2'b11, 2'b00, 1'b0);
        clr();
        st(2'b00, 2'b00, 2'b00, 2'b00, 1'b1);
        avg_oc_event = 2'b10;
        cyc(1);
        avg_oc_event = 2'b00;
        st(2'b00, 2'b00, 2'b10, 2'b00, 1'b0);
        smp(1'b0, UNDER, 2);
        smp(1'b0, {UC_RST[10], UC_RST[10:0], 4'h0}, 1);
        smp(1'b0, UNDER, 2);
        st(2'b00, 2'b00, 2'b10, 2'b00, 1'b0);
        smp(1'b0, UNDER, 1);
        avg_uc_event = 2'b10;
        cyc(1);
        avg_uc_event = 2'b00;
        st(2'b00, 2'b00, 2'b10, 2'b11, 1'b0);
        clr();
        enable_pin = 2'b01;
        operation_on = 2'b11;
        uv_hit(5);
        st(2'b01, 2'b00, 2'b00, 2'b00, 1'b1);
        power_good_flag = 2'b01;
        cyc(4);
        uv_hit(4);
        st(2'b00, 2'b01, 2'b00, 2'b00, 1'b0);
        cyc(400);
        st(2'b00, 2'b01, 2'b00, 2'b00, 1'b0);
        clr();
        st(2'b01, 2'b00, 2'b00, 2'b00, 1'b1);
        wr(1'b0, ofrl_pkg::CMD_UV_ACTION, 16'hAB00, 2'b10);
        rd(1'b0, ofrl_pkg::CMD_UV_ACTION, 16'h0000);
        uv_hit(4);
        st(2'b01, 2'b01, 2'b00, 2'b00, 1'b0);
        clr();
        wr(1'b0, ofrl_pkg::CMD_UV_ACTION, 16'h00B9, 2'b10);
        uv_hit(4);
        for (int k = 0; k < 400 && output_enable[0] !== 1'b1; k++) cyc(1);
        uv_hit(3);
        cyc(RT - 6);
        chk({15'h0000, output_enable[0]}, 16'h0000);
        for (int k = 0; k < 8 && output_enable[0] !== 1'b1; k++) cyc(1);
        chk({15'h0000, output_enable[0]}, 16'h0001);
        uv_hit(3);
        other_fault = 2'b01;
        cyc(1);
        other_fault = 2'b00;
        cyc(RT + 20);
        st(2'b00, 2'b01, 2'b00, 2'b00, 1'b0);
        clr();
        uv_hit(3);
        operation_on = 2'b00;
        cyc(1);
        operation_on = 2'b11;
        st(2'b01, 2'b01, 2'b00, 2'b00, 1'b0);
        bias_ok = 1'b0;
        cyc(2);
        st(2'b00, 2'b01, 2'b00, 2'b00, 1'b0);
        bias_ok = 1'b1;
        st(2'b01, 2'b01, 2'b00, 2'b00, 1'b0);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        final_report();
    end
endmodule : ofrl_fault_limits_test
`default_nettype wire

/* verif/ofrl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrl_host_model (
    input wire logic mclk, // clock
    output logic cmd_valid, // strobe
    output logic cmd_write, // write
    output logic [ofrl_pkg::PAGE_W-1:0] cmd_page, // page
    output logic [7:0] cmd_code, // code
    output logic [15:0] cmd_wdata, // data
    input wire logic cmd_ack, // ack
    input wire logic cmd_nack, // nack
    input wire logic [15:0] cmd_rdata // read data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_page = '0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // one request; answer taken once the answering edge has settled
    task automatic xfer(input logic w, input logic [ofrl_pkg::PAGE_W-1:0] p,
            input logic [7:0] c, input logic [15:0] d,
            output logic [1:0] an, output logic [15:0] r);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_page = p;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge mclk);
        an = {cmd_ack, cmd_nack};
        r = cmd_rdata;
        cmd_valid = 1'b0;
        cmd_wdata = ~d;
    endtask : xfer
endmodule : ofrl_host_model
`default_nettype wire

/* verilog/ofrl_fault_limits.sv */
// Contract
// - an undervoltage fault pulls the active-low alert line low
// - the fault sets a sticky status bit cleared only by clear-faults
// - response codes 00/01 unused; 10/11 disable output then follow retry field
// - retry code 000 keeps output off until faults cleared; 001-110 unused
// - retry 111 restarts until commanded off, bias lost or other fault
// - restart interval is (delay field plus one) times 35 ms; here timed from the last restart, clear or disable, not from the shutdown
// - peak limit compared only with samples after blanking
// - overcurrent declared after configured consecutive samples over the limit
// - peak detector shares overcurrent status bit and response with averaged limit
// - valley limit compared only with samples after blanking
// - undercurrent declared after configured consecutive samples past the limit
// - valley detector shares undercurrent status bit and response with averaged limit
// - limits are signed exponent and mantissa words, range -100 A to 100 A
// - limits are paged, two bytes, read/write and write protected
// - peak limit loads from the strap selection after reset
// - valley limit loads as the negative of the strapped peak limit
// - undervoltage reported only after power good; masked in ramp and when off
// - undervoltage action resets to 80h: shut down, no restart
`timescale 1ns/1ps
`default_nettype none
module ofrl_fault_limits #(
    parameter int PAGES = 2,
    parameter int TICK_CYCLES = ofrl_pkg::TICK_CYCLES,
    parameter logic [63:0] STRAP_OC_LIMITS = 64'h0028_001E_0014_000A
) (
    input wire logic mclk, // clock
    input wire logic rst, // async reset
    input wire logic cmd_valid, // command strobe
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic [ofrl_pkg::PAGE_W-1:0] cmd_page, // page
    input wire logic [7:0] cmd_code, // command code
    input wire logic [15:0] cmd_wdata, // write data
    input wire logic write_protect, // blocks writes
    input wire logic clear_faults, // clear-faults strobe
    output logic cmd_ack, // accepted
    output logic cmd_nack, // refused
    output logic [15:0] cmd_rdata, // read data
    input wire logic [1:0] cfg_strap, // strap pin
    input wire logic [PAGES-1:0] uv_detect, // undervoltage comparator
    input wire logic [PAGES-1:0] power_good_flag, // power good
    input wire logic [PAGES-1:0] enable_pin, // enable pin
    input wire logic [PAGES-1:0] operation_on, // operation command on
    input wire logic bias_ok, // bias power present
    input wire logic [PAGES-1:0] other_fault, // other fault shutdown
    input wire ofrl_pkg::ofrl_sample_t sample, // current sample
    input wire logic blank_done, // blanking over
    input wire logic [3:0] consec_needed, // consecutive count
    input wire logic [PAGES-1:0] avg_oc_event, // averaged oc fault
    input wire logic [PAGES-1:0] avg_uc_event, // averaged uc fault
    output logic [PAGES-1:0] output_enable, // power stage enable
    output logic alert_line_n, // alert, active low
    output logic [PAGES-1:0] uv_status, // uv fault bit
    output logic [PAGES-1:0] oc_status, // oc fault bit
    output logic [PAGES-1:0] uc_status, // uc fault bit
    output logic [PAGES-1:0] oc_response_req, // oc response pulse
    output logic [PAGES-1:0] uc_response_req // uc response pulse
);

    function automatic logic signed [31:0] lin11_fix(input logic [15:0] w);
        logic signed [31:0] m;
        logic signed [6:0] sh;
        m = {{21{w[ofrl_pkg::MANT_HI]}}, w[ofrl_pkg::MANT_HI:0]};
        sh = $signed({{2{w[ofrl_pkg::EXP_HI]}}, w[ofrl_pkg::EXP_HI:ofrl_pkg::EXP_LO]})
            + 7'(ofrl_pkg::FRAC_BITS);
        lin11_fix = sh[6] ? (m >>> 6'(-sh)) : (m <<< sh[5:0]);
    endfunction : lin11_fix

    function automatic logic [15:0] lin11_neg(input logic [15:0] w);
        lin11_neg = {w[ofrl_pkg::EXP_HI:ofrl_pkg::EXP_LO], 11'(-w[ofrl_pkg::MANT_HI:0])};
    endfunction : lin11_neg

    function automatic logic [8:0] retry_ms(input logic [2:0] d);
        retry_ms = 9'((9'(d) + 9'h001) * 9'(ofrl_pkg::RETRY_UNIT_MS));
    endfunction : retry_ms

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and millisecond tick
    logic [PAGES-1:0] uv_m_r, uv_s_r, pg_m_r, pg_s_r, en_m_r, en_s_r;
    logic [1:0] strap_m_r, strap_s_r;
    logic bias_m_r, bias_s_r;
    logic [15:0] div_r, div_nxt;
    logic tick;

    always_comb begin
        tick = (div_r == 16'(TICK_CYCLES - 1));
        div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            uv_m_r <= '0;
            uv_s_r <= '0;
            pg_m_r <= '0;
            pg_s_r <= '0;
            en_m_r <= '0;
            en_s_r <= '0;
            strap_m_r <= 2'h0;
            strap_s_r <= 2'h0;
            bias_m_r <= 1'b0;
            bias_s_r <= 1'b0;
            div_r <= 16'h0000;
        end else begin
            uv_m_r <= uv_detect;
            uv_s_r <= uv_m_r;
            pg_m_r <= power_good_flag;
            pg_s_r <= pg_m_r;
            en_m_r <= enable_pin;
            en_s_r <= en_m_r;
            strap_m_r <= cfg_strap;
            strap_s_r <= strap_m_r;
            bias_m_r <= bias_ok;
            bias_s_r <= bias_m_r;
            div_r <= div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // paged command registers
    logic [7:0] uv_act_r [PAGES], uv_act_nxt [PAGES];
    logic [15:0] oc_lim_r [PAGES], oc_lim_nxt [PAGES];
    logic [15:0] uc_lim_r [PAGES], uc_lim_nxt [PAGES];
    logic [1:0] settle_r, settle_nxt;
    logic loaded_r, loaded_nxt;
    logic ack_nxt, nack_nxt;
    logic [15:0] rdata_nxt;
    logic [15:0] strap_lim;
    logic known;

    always_comb begin
        settle_nxt = settle_r;
        loaded_nxt = loaded_r;
        ack_nxt = 1'b0;
        nack_nxt = 1'b0;
        rdata_nxt = cmd_rdata;
        strap_lim = STRAP_OC_LIMITS[16*strap_s_r +: 16];
        known = (cmd_code == ofrl_pkg::CMD_UV_ACTION) || (cmd_code == ofrl_pkg::CMD_OC_LIMIT)
            || (cmd_code == ofrl_pkg::CMD_UC_LIMIT);
        for (int i = 0; i < PAGES; i++) begin
            uv_act_nxt[i] = uv_act_r[i];
            oc_lim_nxt[i] = oc_lim_r[i];
            uc_lim_nxt[i] = uc_lim_r[i];
        end
        if (!loaded_r) begin
            if (settle_r == 2'(ofrl_pkg::STRAP_SETTLE)) begin
                loaded_nxt = 1'b1;
                for (int i = 0; i < PAGES; i++) begin
                    oc_lim_nxt[i] = strap_lim;
                    uc_lim_nxt[i] = lin11_neg(strap_lim);
                end
            end else begin
                settle_nxt = settle_r + 2'h1;
            end
        end
        if (cmd_valid) begin
            if (!loaded_r || !known || (int'(cmd_page) >= PAGES)
                || (cmd_write && write_protect)) begin
                nack_nxt = 1'b1;
            end else begin
                ack_nxt = 1'b1;
                if (cmd_write) begin
                    case (cmd_code)
                        ofrl_pkg::CMD_UV_ACTION: uv_act_nxt[cmd_page] = cmd_wdata[7:0];
                        ofrl_pkg::CMD_OC_LIMIT: oc_lim_nxt[cmd_page] = cmd_wdata;
                        ofrl_pkg::CMD_UC_LIMIT: uc_lim_nxt[cmd_page] = cmd_wdata;
                        default: ack_nxt = 1'b1;
                    endcase
                end else begin
                    case (cmd_code)
                        ofrl_pkg::CMD_UV_ACTION: rdata_nxt = {8'h00, uv_act_r[cmd_page]};
                        ofrl_pkg::CMD_OC_LIMIT: rdata_nxt = oc_lim_r[cmd_page];
                        ofrl_pkg::CMD_UC_LIMIT: rdata_nxt = uc_lim_r[cmd_page];
                        default: rdata_nxt = 16'h0000;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PAGES; i++) begin
                uv_act_r[i] <= ofrl_pkg::UV_ACTION_RST;
                oc_lim_r[i] <= 16'h0000;
                uc_lim_r[i] <= 16'h0000;
            end
            settle_r <= 2'h0;
            loaded_r <= 1'b0;
            cmd_ack <= 1'b0;
            cmd_nack <= 1'b0;
            cmd_rdata <= 16'h0000;
        end else begin
            for (int i = 0; i < PAGES; i++) begin
                uv_act_r[i] <= uv_act_nxt[i];
                oc_lim_r[i] <= oc_lim_nxt[i];
                uc_lim_r[i] <= uc_lim_nxt[i];
            end
            settle_r <= settle_nxt;
            loaded_r <= loaded_nxt;
            cmd_ack <= ack_nxt;
            cmd_nack <= nack_nxt;
            cmd_rdata <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peak and valley detectors
    logic [3:0] oc_cnt_r [PAGES], oc_cnt_nxt [PAGES];
    logic [3:0] uc_cnt_r [PAGES], uc_cnt_nxt [PAGES];
    logic [PAGES-1:0] oc_hit_r, oc_hit_nxt, uc_hit_r, uc_hit_nxt;
    logic signed [31:0] amps_fix;
    logic [3:0] need;
    logic over, under;

    always_comb begin
        amps_fix = 32'(sample.amps);
        need = (consec_needed == 4'h0) ? 4'h1 : consec_needed;
        over = 1'b0;
        under = 1'b0;
        for (int i = 0; i < PAGES; i++) begin
            oc_cnt_nxt[i] = oc_cnt_r[i];
            uc_cnt_nxt[i] = uc_cnt_r[i];
            oc_hit_nxt[i] = 1'b0;
            uc_hit_nxt[i] = 1'b0;
            if (sample.valid && blank_done && (int'(sample.page) == i)) begin
                over = amps_fix > lin11_fix(oc_lim_r[i]);
                under = amps_fix < lin11_fix(uc_lim_r[i]);
                oc_cnt_nxt[i] = !over ? 4'h0 : (oc_cnt_r[i] == 4'hF) ? 4'hF : oc_cnt_r[i] + 4'h1;
                uc_cnt_nxt[i] = !under ? 4'h0 : (uc_cnt_r[i] == 4'hF) ? 4'hF : uc_cnt_r[i] + 4'h1;
                oc_hit_nxt[i] = over && (oc_cnt_nxt[i] >= need);
                uc_hit_nxt[i] = under && (uc_cnt_nxt[i] >= need);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PAGES; i++) begin
                oc_cnt_r[i] <= 4'h0;
                uc_cnt_r[i] <= 4'h0;
            end
            oc_hit_r <= '0;
            uc_hit_r <= '0;
        end else begin
            for (int i = 0; i < PAGES; i++) begin
                oc_cnt_r[i] <= oc_cnt_nxt[i];
                uc_cnt_r[i] <= uc_cnt_nxt[i];
            end
            oc_hit_r <= oc_hit_nxt;
            uc_hit_r <= uc_hit_nxt;
        end
    end

    assign oc_response_req = oc_hit_r | avg_oc_event;
    assign uc_response_req = uc_hit_r | avg_uc_event;

    ////////////////////////////////////////////////////////////////////////////
    // status bits and undervoltage response
    ofrl_pkg::ofrl_state_t st_r [PAGES], st_nxt [PAGES];
    logic [8:0] rcnt_r [PAGES], rcnt_nxt [PAGES];
    logic [PAGES-1:0] pg_seen_r, pg_seen_nxt;
    logic [PAGES-1:0] uv_st_r, uv_st_nxt, oc_st_r, oc_st_nxt, uc_st_r, uc_st_nxt;
    logic [PAGES-1:0] en_cmd, out_on, uv_q;

    always_comb begin
        for (int i = 0; i < PAGES; i++) begin
            en_cmd[i] = en_s_r[i] && operation_on[i];
            out_on[i] = (st_r[i] == ofrl_pkg::ST_RUN) && en_cmd[i] && bias_s_r;
            uv_q[i] = uv_s_r[i] && pg_seen_r[i] && out_on[i];
            pg_seen_nxt[i] = out_on[i] && (pg_seen_r[i] || pg_s_r[i]);
            st_nxt[i] = st_r[i];
            rcnt_nxt[i] = (tick && rcnt_r[i] != 9'h1FF) ? rcnt_r[i] + 9'h001 : rcnt_r[i];
            // clear then set, so a new event wins
            uv_st_nxt[i] = (uv_st_r[i] && !clear_faults) || uv_q[i];
            oc_st_nxt[i] = (oc_st_r[i] && !clear_faults) || oc_response_req[i];
            uc_st_nxt[i] = (uc_st_r[i] && !clear_faults) || uc_response_req[i];
            case (st_r[i])
                ofrl_pkg::ST_RUN: begin
                    if (!en_cmd[i] || !bias_s_r) begin
                        rcnt_nxt[i] = 9'h000;
                    end else if (uv_q[i] && uv_act_r[i][ofrl_pkg::RESP_MSB]) begin
                        if (uv_act_r[i][ofrl_pkg::RETRY_HI:ofrl_pkg::RETRY_LO]
                            == ofrl_pkg::RETRY_CONT) begin
                            st_nxt[i] = ofrl_pkg::ST_RETRY;
                        end else begin
                            st_nxt[i] = ofrl_pkg::ST_LATCHED;
                        end
                    end
                end
                ofrl_pkg::ST_LATCHED: begin
                    if (clear_faults) begin
                        st_nxt[i] = ofrl_pkg::ST_RUN;
                        rcnt_nxt[i] = 9'h000;
                    end
                end
                ofrl_pkg::ST_RETRY: begin
                    if (!en_cmd[i] || !bias_s_r) begin
                        st_nxt[i] = ofrl_pkg::ST_RUN;
                        rcnt_nxt[i] = 9'h000;
                    end else if (other_fault[i]) begin
                        st_nxt[i] = ofrl_pkg::ST_LATCHED;
                    end else if (rcnt_r[i] >=
                        retry_ms(uv_act_r[i][ofrl_pkg::DELAY_HI:ofrl_pkg::DELAY_LO])) begin
                        st_nxt[i] = ofrl_pkg::ST_RUN;
                        rcnt_nxt[i] = 9'h000;
                    end
                end
                default: st_nxt[i] = ofrl_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PAGES; i++) begin
                st_r[i] <= ofrl_pkg::ST_RUN;
                rcnt_r[i] <= 9'h000;
            end
            pg_seen_r <= '0;
            uv_st_r <= '0;
            oc_st_r <= '0;
            uc_st_r <= '0;
        end else begin
            for (int i = 0; i < PAGES; i++) begin
                st_r[i] <= st_nxt[i];
                rcnt_r[i] <= rcnt_nxt[i];
            end
            pg_seen_r <= pg_seen_nxt;
            uv_st_r <= uv_st_nxt;
            oc_st_r <= oc_st_nxt;
            uc_st_r <= uc_st_nxt;
        end
    end

    assign output_enable = out_on;
    assign uv_status = uv_st_r;
    assign oc_status = oc_st_r;
    assign uc_status = uc_st_r;
    assign alert_line_n = ~|{uv_st_r, oc_st_r, uc_st_r};

endmodule : ofrl_fault_limits
`default_nettype wire

/* verilog/ofrl_pkg.sv */
`default_nettype none
package ofrl_pkg;
    // command codes of the three paged commands
    localparam logic [7:0] CMD_UV_ACTION = 8'h45;
    localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
    localparam logic [7:0] CMD_UC_LIMIT = 8'h4B;
    localparam logic [7:0] UV_ACTION_RST = 8'h80;
    // undervoltage action fields
    localparam int RESP_MSB = 7;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [2:0] RETRY_CONT = 3'h7;
    // linear-11 word fields
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MANT_HI = 10;
    // current samples are signed amperes with this many fraction bits
    localparam int FRAC_BITS = 4;
    // timing
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int RETRY_UNIT_MS = 35;
    localparam int STRAP_SETTLE = 2;
    localparam int PAGE_W = 1;
    typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_RETRY} ofrl_state_t;
    typedef struct packed {
        logic valid;
        logic [PAGE_W-1:0] page;
        logic signed [15:0] amps;
    } ofrl_sample_t;
endpackage : ofrl_pkg
`default_nettype wire
